// *** inc/mfc_consts.svh ***
/*
 * Offsets, reset values and timing counts of the frame scheduler.
 * Assumes a 250 MHz core clock and symbol-unit frame timing.
 */
`ifndef MFC_CONSTS_SVH
`define MFC_CONSTS_SVH
`define MFC_OFF_CTRL 8'h00
`define MFC_OFF_CFG 8'h04
`define MFC_OFF_CFP 8'h08
`define MFC_OFF_STAT 8'h0C
`define MFC_OFF_AREQ 8'h10
`define MFC_OFF_ARSP 8'h14
`define MFC_OFF_JOIN 8'h18
`define MFC_OFF_JRSP 8'h1C
`define MFC_CTRL_RST 32'h0000_0000
`define MFC_SPF_RST 8'h20
`define MFC_CFP_RST 16'h0000
`define MFC_CLK_NS 4
`define MFC_SYM_NS 2240
`define MFC_SYM_CYC ((`MFC_SYM_NS + `MFC_CLK_NS - 1) / `MFC_CLK_NS)
`define MFC_GUARD 16'h000A
`define MFC_BCN_CC 16'h0004
`define MFC_BCN_R 16'h000C
`define MFC_BCN_QR 16'h0008
`define MFC_MIN_SCP 16'h0040
`define MFC_FLEN0 16'h0114
`define MFC_FLEN1 16'h0228
`define MFC_FLEN2 16'h0450
`define MFC_FLEN3 16'h08A0
`define MFC_LEAD 4'h2
`define MFC_KEY_SF 8'h04
`define MFC_MAX_NODE 14'h3FFD
`define MFC_MAX_SW 8'hFF
`define MFC_LFSR_RST 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3211
`endif

// *** inc/mfc_pkg.sv ***
/*
 * Types shared by the frame scheduler and its bench.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mfc_pkg;
    typedef enum logic {mfc_ind_idle, mfc_ind_send} mfc_ind_st_t;
    typedef struct packed {
        logic [24:0] rsvd;
        logic bcn_all;
        logic [1:0] robust;
        logic key_prof;
        logic [1:0] flen;
        logic enable;
    } mfc_ctrl_t;
    typedef struct packed {
        logic go;
        logic [1:0] modulation;
        logic type_b;
        logic max_power;
    } mfc_beacon_t;
    typedef struct packed {
        logic valid;
        logic [7:0] hop;
        logic [7:0] dest;
        logic [15:0] start;
        logic [15:0] len;
        logic [3:0] lead;
    } mfc_ind_t;
endpackage

// *** design/mfc_frame_sched.sv ***
/*
 * Root-node frame scheduler: frame timing, beacons, allocations,
 * joining, switch identifiers and key sequence, AXI4-Lite registers.
 * Assumes inputs synchronous to core_clk and the peers on the line.
 */
`timescale 1ns/1ps
`include "mfc_consts.svh"
module mfc_frame_sched (
    input wire logic core_clk, // core clock
    input wire logic rst_b, // async reset
    input wire logic ce, // clock enable
    input wire logic [7:0] s_awaddr, // write address
    input wire logic s_awvalid, // write address valid
    output logic s_awready, // write address ready
    input wire logic [31:0] s_wdata, // write data
    input wire logic [3:0] s_wstrb, // byte enables
    input wire logic s_wvalid, // write data valid
    output logic s_wready, // write data ready
    output logic [1:0] s_bresp, // write response
    output logic s_bvalid, // response valid
    input wire logic s_bready, // response ready
    input wire logic [7:0] s_araddr, // read address
    input wire logic s_arvalid, // read address valid
    output logic s_arready, // read address ready
    output logic [31:0] s_rdata, // read data
    output logic [1:0] s_rresp, // read response
    output logic s_rvalid, // read data valid
    input wire logic s_rready, // read data ready
    output logic frame_start, // first symbol of frame
    output logic [7:0] frame_num, // modulo frame number
    output logic cfp_active, // contention-free part
    output logic guard_active, // guard interval
    output logic scp_active, // shared period
    output logic alloc_window, // granted window
    output logic frame_change_notice, // structure change
    output mfc_pkg::mfc_beacon_t beacon, // beacon request
    output mfc_pkg::mfc_ind_t alloc_ind, // allocation indication
    output logic [127:0] key_seq, // key sequence
    output logic key_valid // new key sequence
);

    function automatic logic [15:0] flen_of(input logic [1:0] s);
        case (s)
            2'h0: flen_of = `MFC_FLEN0;
            2'h1: flen_of = `MFC_FLEN1;
            2'h2: flen_of = `MFC_FLEN2;
            default: flen_of = `MFC_FLEN3;
        endcase
    endfunction

    function automatic logic [15:0] bcn_of(input logic [1:0] m);
        case (m)
            2'h1: bcn_of = `MFC_BCN_R;
            2'h2: bcn_of = `MFC_BCN_QR;
            default: bcn_of = `MFC_BCN_CC;
        endcase
    endfunction

    function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
        max16 = (a > b) ? a : b;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        merge = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                merge[8*i +: 8] = n[8*i +: 8];
            end
        end
    endfunction

    localparam logic [15:0] MIN_CFP = 16'(`MFC_BCN_CC + 2 * `MFC_GUARD);
    localparam logic [9:0] SYM_LAST = 10'(`MFC_SYM_CYC - 1);

    mfc_pkg::mfc_ctrl_t ctrl;
    logic [7:0] spf;
    logic [15:0] cfp_req;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] arsp, jrsp;
    logic [9:0] sym_div;
    logic [15:0] sym_cnt, cur_flen, cur_cfp, cur_bcn;
    logic [15:0] al_start, al_len;
    logic al_on, al_pend;
    logic [3:0] al_lead;
    logic [7:0] al_dest, ind_last;
    mfc_pkg::mfc_ind_st_t ind_st;
    logic [13:0] node_ctr;
    logic [7:0] sw_ctr, sf_ctr;
    logic [127:0] lfsr;

    // register bus decode
    wire do_wr = aw_held & w_held & ~s_bvalid & ce;
    wire ar_go = s_arvalid & s_arready;
    wire wr_ctrl = do_wr & (aw_addr == `MFC_OFF_CTRL);
    wire wr_cfg = do_wr & (aw_addr == `MFC_OFF_CFG);
    wire wr_cfp = do_wr & (aw_addr == `MFC_OFF_CFP);
    wire wr_areq = do_wr & (aw_addr == `MFC_OFF_AREQ);
    wire wr_join = do_wr & (aw_addr == `MFC_OFF_JOIN);
    wire wr_map = wr_ctrl | wr_cfg | wr_cfp | wr_areq | wr_join | (aw_addr == `MFC_OFF_STAT)
                  | (aw_addr == `MFC_OFF_ARSP) | (aw_addr == `MFC_OFF_JRSP);
    wire [7:0] ra = s_araddr;
    wire rd_map = (ra <= `MFC_OFF_JRSP) & (ra[1:0] == 2'h0);
    wire [31:0] stat = {21'h00_0000, frame_change_notice, scp_active, cfp_active, frame_num};
    wire [31:0] rd_mux = (ra == `MFC_OFF_CTRL) ? 32'(ctrl) :
                         (ra == `MFC_OFF_CFG) ? {24'h00_0000, spf} :
                         (ra == `MFC_OFF_CFP) ? {cur_cfp, cfp_req} :
                         (ra == `MFC_OFF_STAT) ? stat :
                         (ra == `MFC_OFF_ARSP) ? arsp :
                         (ra == `MFC_OFF_JRSP) ? jrsp : 32'h0000_0000;
    assign s_awready = ce & ~aw_held;
    assign s_wready = ce & ~w_held;
    assign s_arready = ce & ~s_rvalid;

    // frame timing
    wire sym_tick = ce & ctrl.enable & (sym_div == SYM_LAST);
    wire frame_end = sym_tick & (sym_cnt == cur_flen - 16'h0001);
    wire [7:0] spf_eff = (spf == 8'h00) ? 8'h01 : spf;
    wire sf_end = frame_end & (frame_num >= spf_eff - 8'h01);
    wire [7:0] next_fnum = sf_end ? 8'h00 : frame_num + 8'h01;

    // layout for the next frame
    wire [15:0] next_flen = flen_of(ctrl.flen);
    wire [15:0] next_bcn = bcn_of(ctrl.robust);
    wire [15:0] slot_end = 16'(`MFC_GUARD + next_bcn + `MFC_GUARD);
    wire [15:0] al_need = (al_on | al_pend) ? 16'(al_start + al_len + `MFC_GUARD) : 16'h0000;
    wire [15:0] cfp_lim = next_flen - `MFC_MIN_SCP;
    wire [15:0] cfp_want = max16(max16(cfp_req, al_need), max16(slot_end, MIN_CFP));
    wire [15:0] next_cfp = (cfp_want > cfp_lim) ? cfp_lim : cfp_want;
    wire layout_chg = (next_cfp != cur_cfp) | (next_flen != cur_flen);

    // allocation request decode
    // request fields come from the held data word, the bus may have moved on
    wire [15:0] rq_len = w_data[15:0];
    wire [7:0] rq_hops = w_data[23:16];
    wire [7:0] rq_dest = w_data[31:24];
    wire rq_rel = wr_areq & (rq_len == 16'h0000);
    wire [16:0] rq_end = 17'(slot_end) + 17'(rq_len) + 17'(`MFC_GUARD);
    wire rq_ok = wr_areq & ~rq_rel & (ind_st == mfc_pkg::mfc_ind_idle) & (rq_end <= 17'(cfp_lim));

    // symbol position flags
    wire in_cfp = sym_cnt < cur_cfp;
    wire in_guard = (sym_cnt < `MFC_GUARD) | (in_cfp & (sym_cnt >= cur_cfp - `MFC_GUARD));
    wire in_alloc = al_on & (sym_cnt >= al_start) & (sym_cnt < al_start + al_len);
    wire bcn_frame = (frame_num == 8'h00) | ctrl.bcn_all;
    wire bcn_go = sym_tick & bcn_frame & (sym_cnt == `MFC_GUARD - 16'h0001);
    wire key_due = sf_end & ctrl.key_prof & (sf_ctr >= `MFC_KEY_SF - 8'h01);
    wire lfsr_fb = lfsr[127] ^ lfsr[125] ^ lfsr[100] ^ lfsr[98];

    // register bus
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= 2'h0;
            s_rvalid <= 1'b0;
            s_rresp <= 2'h0;
            s_rdata <= 32'h0000_0000;
        end else if (ce) begin
            if (s_awvalid & s_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_awaddr[7:2], 2'h0};
            end else if (do_wr) begin
                aw_held <= 1'b0;
            end
            if (s_wvalid & s_wready) begin
                w_held <= 1'b1;
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end else if (do_wr) begin
                w_held <= 1'b0;
            end
            if (do_wr) begin
                s_bvalid <= 1'b1;
                s_bresp <= wr_map ? 2'h0 : 2'h2;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
            if (ar_go) begin
                s_rvalid <= 1'b1;
                s_rdata <= rd_mux;
                s_rresp <= rd_map ? 2'h0 : 2'h2;
            end else if (s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // control registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= `MFC_CTRL_RST;
            spf <= `MFC_SPF_RST;
            cfp_req <= `MFC_CFP_RST;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl <= merge(32'(ctrl), w_data, w_strb) & 32'h0000_007F;
            end
            if (wr_cfg & w_strb[0]) begin
                spf <= w_data[7:0];
            end
            if (wr_cfp) begin
                cfp_req <= 16'(merge({16'h0000, cfp_req}, w_data, w_strb));
            end
        end
    end

    // symbol and frame counters, layout latched per frame
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sym_div <= 10'h000;
            sym_cnt <= 16'h0000;
            frame_num <= 8'h00;
            cur_flen <= `MFC_FLEN0;
            cur_cfp <= MIN_CFP;
            cur_bcn <= `MFC_BCN_CC;
            frame_change_notice <= 1'b0;
            frame_start <= 1'b0;
        end else if (ce) begin
            sym_div <= (~ctrl.enable | sym_tick) ? 10'h000 : sym_div + 10'h001;
            frame_start <= frame_end;
            frame_change_notice <= frame_end & layout_chg;
            if (!ctrl.enable) begin
                sym_cnt <= 16'h0000;
            end else if (frame_end) begin
                sym_cnt <= 16'h0000;
                frame_num <= next_fnum;
                cur_flen <= next_flen;
                cur_cfp <= next_cfp;
                cur_bcn <= next_bcn;
            end else if (sym_tick) begin
                sym_cnt <= sym_cnt + 16'h0001;
            end
        end
    end

    // position outputs
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfp_active <= 1'b0;
            guard_active <= 1'b0;
            scp_active <= 1'b0;
            alloc_window <= 1'b0;
            beacon <= '0;
        end else if (ce) begin
            cfp_active <= ctrl.enable & in_cfp;
            guard_active <= ctrl.enable & in_guard;
            scp_active <= ctrl.enable & ~in_cfp;
            alloc_window <= ctrl.enable & in_alloc & ~in_guard;
            beacon.go <= bcn_go;
            beacon.modulation <= ctrl.robust;
            beacon.type_b <= (ctrl.robust != 2'h0);
            beacon.max_power <= 1'b1;
        end
    end

    // allocations and their indications
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            al_on <= 1'b0;
            al_pend <= 1'b0;
            al_lead <= 4'h0;
            al_start <= 16'h0000;
            al_len <= 16'h0000;
            al_dest <= 8'h00;
            ind_last <= 8'h00;
            ind_st <= mfc_pkg::mfc_ind_idle;
            alloc_ind <= '0;
            arsp <= 32'h0000_0000;
        end else if (ce) begin
            if (rq_rel) begin
                al_on <= 1'b0;
                al_pend <= 1'b0;
            end else if (rq_ok) begin
                al_on <= 1'b0;
                al_pend <= 1'b1;
                al_lead <= `MFC_LEAD;
                al_start <= slot_end;
                al_len <= rq_len;
                al_dest <= rq_dest;
                ind_last <= rq_hops;
                arsp <= {1'b1, 7'h00, `MFC_LEAD, 4'h0, slot_end};
            end else if (wr_areq) begin
                arsp <= 32'h0000_0000;
            end else if (frame_end & al_pend) begin
                al_lead <= al_lead - 4'h1;
                if (al_lead == 4'h1) begin
                    al_pend <= 1'b0;
                    al_on <= 1'b1;
                end
            end
            alloc_ind.valid <= 1'b0;
            unique case (ind_st)
                mfc_pkg::mfc_ind_idle: begin
                    if (rq_ok) begin
                        ind_st <= mfc_pkg::mfc_ind_send;
                        alloc_ind <= {1'b1, 8'h00, rq_dest, slot_end, rq_len, `MFC_LEAD};
                    end
                end
                mfc_pkg::mfc_ind_send: begin
                    if (alloc_ind.hop == ind_last) begin
                        ind_st <= mfc_pkg::mfc_ind_idle;
                    end else begin
                        alloc_ind.valid <= 1'b1;
                        alloc_ind.hop <= alloc_ind.hop + 8'h01;
                    end
                end
            endcase
        end
    end

    // joining, promotion and key sequence
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            node_ctr <= 14'h0001;
            sw_ctr <= 8'h01;
            jrsp <= 32'h0000_0000;
            sf_ctr <= 8'h00;
            lfsr <= `MFC_LFSR_RST;
            key_seq <= 128'h0;
            key_valid <= 1'b0;
        end else if (ce) begin
            lfsr <= {lfsr[126:0], lfsr_fb};
            key_valid <= key_due;
            if (key_due) begin
                key_seq <= lfsr;
                sf_ctr <= 8'h00;
            end else if (sf_end & ctrl.key_prof) begin
                sf_ctr <= sf_ctr + 8'h01;
            end
            if (wr_join & w_data[1]) begin
                jrsp <= {(sw_ctr != `MFC_MAX_SW), 1'b1, 22'h00_0000, sw_ctr};
                if (sw_ctr != `MFC_MAX_SW) begin
                    sw_ctr <= sw_ctr + 8'h01;
                end
            end else if (wr_join) begin
                jrsp <= {(node_ctr != `MFC_MAX_NODE), 17'h0_0000, node_ctr};
                if (node_ctr != `MFC_MAX_NODE) begin
                    node_ctr <= node_ctr + 14'h0001;
                end
            end
        end
    end

    // checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic bcn_seen;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bcn_seen <= 1'b0;
        end else if (ce) begin
            bcn_seen <= sf_end ? 1'b0 : (bcn_seen | bcn_go);
        end
    end

    property p_frame_wrap;
        frame_end |=> sym_cnt == 16'h0000 && frame_start;
    endproperty
    a_frame_wrap: assert property (p_frame_wrap) else $error("frame did not wrap");
    property p_fnum_mod;
        sf_end |=> frame_num == 8'h00;
    endproperty
    a_fnum_mod: assert property (p_fnum_mod) else $error("frame number not modulo");
    property p_cfp_min;
        cur_cfp >= MIN_CFP;
    endproperty
    a_cfp_min: assert property (p_cfp_min) else $error("contention-free part short");
    property p_scp_min;
        cur_flen - cur_cfp >= `MFC_MIN_SCP;
    endproperty
    a_scp_min: assert property (p_scp_min) else $error("shared period short");
    property p_flen_set;
        cur_flen inside {`MFC_FLEN0, `MFC_FLEN1, `MFC_FLEN2, `MFC_FLEN3};
    endproperty
    a_flen_set: assert property (p_flen_set) else $error("illegal frame length");
    property p_bcn_sf;
        sf_end && spf_eff > 8'h01 && cur_flen > `MFC_GUARD |-> bcn_seen || bcn_go;
    endproperty
    a_bcn_sf: assert property (p_bcn_sf) else $error("superframe without beacon");
    property p_bcn_phy;
        beacon.go |-> beacon.max_power && beacon.type_b == (beacon.modulation != 2'h0);
    endproperty
    a_bcn_phy: assert property (p_bcn_phy) else $error("beacon phy setting wrong");
    property p_ind_order;
        alloc_ind.valid && ce && alloc_ind.hop != ind_last |=> alloc_ind.valid && alloc_ind.hop == $past(alloc_ind.hop) + 8'h01;
    endproperty
    a_ind_order: assert property (p_ind_order) else $error("indication order broken");
    property p_grant_cfp;
        alloc_window |-> cfp_active && !guard_active && !scp_active;
    endproperty
    a_grant_cfp: assert property (p_grant_cfp) else $error("grant outside part");
    c_change: cover property (frame_change_notice);
    c_multihop: cover property (alloc_ind.valid && alloc_ind.hop == 8'h02);
    c_key: cover property (key_valid);
    c_sf_wrap: cover property (sf_end);
endmodule

// *** verification/mfc_peer_model.sv ***
/*
 * Behavioural peer node on the shared line, facing the frame scheduler.
 * Assumes the scheduler's phase levels and beacon pulse on core_clk.
 */
`timescale 1ns/1ps
module mfc_peer_model (
    input wire logic core_clk, // core clock
    input wire logic rst_b, // async reset
    input wire mfc_pkg::mfc_beacon_t beacon, // beacon from root
    input wire logic cfp_active, // contention-free part
    input wire logic scp_active, // shared period
    input wire logic alloc_window, // granted window
    output logic peer_tx, // peer transmitting
    output logic [15:0] bcn_seen // beacons tracked
);
    logic [3:0] backoff;
    logic [3:0] next_backoff;
    assign next_backoff = scp_active ? ((backoff == 4'h0) ? 4'h0 : backoff - 4'h1) : 4'h7;
    // silent in the free part outside the grant, sensed backoff in the shared period
    assign peer_tx = (cfp_active & alloc_window) | (scp_active & (backoff == 4'h0));
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            backoff <= 4'h7;
            bcn_seen <= 16'h0000;
        end else begin
            backoff <= next_backoff;
            if (beacon.go) begin
                bcn_seen <= bcn_seen + 16'h0001;
            end
        end
    end
endmodule

// *** verification/mac_frame_channel_access_tb_top.sv ***
/*
 * Self-checking bench of the frame scheduler over AXI4-Lite.
 * Assumes the 250 MHz core clock and the peer model beside it.
 */
`timescale 1ns/1ps
`include "mfc_consts.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module mac_frame_channel_access_tb_top;
    logic core_clk = 1'b0, rst_b = 1'b0, ce = 1'b1;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0, s_rdata, rd;
    logic [3:0] s_wstrb = 4'hF;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp, resp;
    logic frame_start, cfp_active, guard_active, scp_active, alloc_window, fcn, key_valid, peer_tx;
    logic [7:0] frame_num;
    logic [127:0] key_seq;
    logic [15:0] bcn_seen;
    mfc_pkg::mfc_beacon_t beacon;
    mfc_pkg::mfc_ind_t alloc_ind;
    mfc_pkg::mfc_ind_t inds[$];
    int num_errors = 0, checks = 0, cyc = 0, seed = 32'hc118, n, hops;
    logic [7:0] rid;
    logic [15:0] len;
    always #2 core_clk = ~core_clk;
    mfc_frame_sched u_mfc_frame_sched (.core_clk(core_clk), .rst_b(rst_b), .ce(ce),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .frame_start(frame_start), .frame_num(frame_num),
        .cfp_active(cfp_active), .guard_active(guard_active), .scp_active(scp_active),
        .alloc_window(alloc_window), .frame_change_notice(fcn), .beacon(beacon),
        .alloc_ind(alloc_ind), .key_seq(key_seq), .key_valid(key_valid));
    mfc_peer_model u_mfc_peer_model (.core_clk(core_clk), .rst_b(rst_b), .beacon(beacon),
        .cfp_active(cfp_active), .scp_active(scp_active), .alloc_window(alloc_window),
        .peer_tx(peer_tx), .bcn_seen(bcn_seen));
    always @(posedge core_clk) begin
        cyc++;
        if (alloc_ind.valid) inds.push_back(alloc_ind);
        if (cyc == 60000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
    endtask
    // handshakes sampled at the rising edge, released right after it
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        s_awaddr <= a; s_wdata <= d; s_awvalid <= 1'b1; s_wvalid <= 1'b1; s_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_awvalid & s_awready) s_awvalid <= 1'b0;
            if (s_wvalid & s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        resp = s_bresp;
        s_bready <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic axi_read(input logic [7:0] a);
        s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_arvalid & s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        rd = s_rdata;
        resp = s_rresp;
        s_rready <= 1'b0;
        @(posedge core_clk);
    endtask
    initial begin
        do_reset();
        axi_read(`MFC_OFF_CTRL); `CHK(rd, `MFC_CTRL_RST)
        axi_read(`MFC_OFF_CFG); `CHK(rd[7:0], `MFC_SPF_RST)
        axi_read(`MFC_OFF_CFP); `CHK(rd, {`MFC_GUARD * 2 + `MFC_BCN_CC, `MFC_CFP_RST})
        axi_read(8'h20); `CHK(resp, 2'h2)
        axi_write(8'h24, 32'h0000_0001); `CHK(resp, 2'h2)
        for (n = 0; n < 4; n++) begin
            axi_write(`MFC_OFF_JOIN, {30'h0, n[1], 1'b0});
            axi_read(`MFC_OFF_JRSP);
            `CHK(rd[31:30], {1'b1, n[1]})
            if (n[1]) `CHK(rd[7:0], 8'(n - 1))
            else `CHK(rd[13:0], 14'(n + 1))
        end
        for (n = 0; n < 3; n++) begin
            hops = ($random(seed) & 3) + n;
            rid = 8'($random(seed));
            len = 16'(($random(seed) & 15) + 1);
            inds.delete();
            axi_write(`MFC_OFF_AREQ, {rid, 8'(hops), len});
            repeat (hops + 4) @(posedge core_clk);
            `CHK(inds.size(), hops + 1)
            foreach (inds[i]) begin
                `CHK(inds[i].hop, 8'(i))
                `CHK({inds[i].len, inds[i].lead}, {len, `MFC_LEAD})
            end
            `CHK(inds[0].dest, rid)
            `CHK(inds[0].start, 16'(`MFC_GUARD * 2 + `MFC_BCN_CC))
            axi_read(`MFC_OFF_ARSP);
            `CHK({rd[31], rd[23:20], rd[15:0]}, {1'b1, `MFC_LEAD, 16'(`MFC_GUARD * 2 + `MFC_BCN_CC)})
        end
        for (n = 0; n < 3; n++) begin
            do_reset();
            axi_write(`MFC_OFF_CTRL, {26'h0, 2'(n), 3'h0, 1'b1});
            repeat (100) @(posedge core_clk);
            `CHK({guard_active, cfp_active, scp_active}, 3'b110)
            `CHK({alloc_window, peer_tx}, 2'b00)
            axi_read(`MFC_OFF_STAT);
            `CHK(rd[9:0], {1'b0, 1'b1, 8'h00})
            while (!beacon.go) @(posedge core_clk);
            @(negedge core_clk);
            `CHK({beacon.modulation, beacon.type_b}, {2'(n), n != 0})
            `CHK(beacon.max_power, 1'b1)
            `CHK({cfp_active, scp_active}, 2'b10)
            @(negedge core_clk);
            `CHK(bcn_seen, 16'h0001)
        end
        final_report();
    end
endmodule
